// ===== sdf_pkg.sv
package sdf_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned MOD_DIV = 128;
    localparam int unsigned MOD_CNT_W = 7;
    localparam logic [6:0] MOD_CNT_LAST = 7'(MOD_DIV - 1);
    localparam int unsigned STAGES = 3;
    localparam int unsigned ACC_W = 28;
    localparam int unsigned DEC_W = 9;
    localparam int unsigned RECIP_W = 25;
    localparam int unsigned PROD_W = ACC_W + RECIP_W;
    localparam int unsigned SCALE_SHIFT = 24;
    // half an output step below the cut, so the scaled word rounds to nearest
    localparam logic [PROD_W-1:0] PROD_HALF = 53'h0000000800000;
    localparam int unsigned DUTY_W = 17;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [1:0] SETTLE_SKIP = 2'h2;
    localparam logic [WORD_W-1:0] WORD_MAX = 16'hffff;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [DUTY_W-1:0] DUTY_MID = 17'h08000;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 17'h10000;
    localparam logic [ACC_W-1:0] ACC_ZERO = 28'h0000000;
    localparam logic [DEC_W-1:0] DEC_ZERO = 9'h000;

    typedef logic [ACC_W-1:0] sdf_acc_t;

    // decimation factor per filter select code
    function automatic logic [DEC_W-1:0] sdf_dec_n(input logic [1:0] sel);
        unique case (sel)
            2'h0: sdf_dec_n = 9'h180;
            2'h1: sdf_dec_n = 9'h140;
            2'h2: sdf_dec_n = 9'h04d;
            2'h3: sdf_dec_n = 9'h026;
        endcase
    endfunction : sdf_dec_n

    // round(2**40 / n**3) for codes 0 and 1, 6 and 1 above it for codes 2 and 3; scales the cubed gain to a 16-bit fraction
    function automatic logic [RECIP_W-1:0] sdf_recip(input logic [1:0] sel);
        unique case (sel)
            2'h0: sdf_recip = 25'h0004bda;
            2'h1: sdf_recip = 25'h0008312;
            2'h2: sdf_recip = 25'h024bfd1;
            2'h3: sdf_recip = 25'h131c07b;
        endcase
    endfunction : sdf_recip

    function automatic logic [WORD_W-1:0] sdf_sat(input logic [DUTY_W-1:0] d);
        sdf_sat = (d >= DUTY_FULL) ? WORD_MAX : d[WORD_W-1:0];
    endfunction : sdf_sat

    // duty 0..1 of the stream; midscale duty is zero differential input
    function automatic logic [WORD_W-1:0] sdf_code(input logic [DUTY_W-1:0] d,
                                                   input logic bipolar);
        logic [DUTY_W-1:0] ofs;
        ofs = d - DUTY_MID;
        if (bipolar) begin
            sdf_code = sdf_sat(d);
        end else if (d < DUTY_MID) begin
            sdf_code = WORD_ZERO;
        end else begin
            sdf_code = sdf_sat({ofs[DUTY_W-2:0], 1'b0});
        end
    endfunction : sdf_code
endpackage : sdf_pkg

// ===== sdf_stream_if.sv
`timescale 1ns/10ps
interface sdf_stream_if #(parameter int unsigned WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sdf_stream_if

// ===== sdf_fifo.sv
`timescale 1ns/10ps
module sdf_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    sdf_stream_if.snk s_in,
    sdf_stream_if.src s_out
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    assign s_in.ready = (cnt_reg != CNT_FULL);
    assign s_out.valid = (cnt_reg != '0);
    assign s_out.data = mem[rd_ptr_reg];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage has no reset; only words below the count are ever shown
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= s_in.data;
        end
    end
endmodule : sdf_fifo

// ===== sdf_filter.sv
`timescale 1ns/10ps
module sdf_filter (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_mod_bit,
    input wire logic i_filter_select_lo,
    input wire logic i_filter_select_hi,
    input wire logic i_polarity_bipolar,
    input wire logic i_filter_sync,
    input wire logic i_rd_ready,
    output logic o_rd_valid,
    output logic [sdf_pkg::WORD_W-1:0] o_rd_data,
    output logic [sdf_pkg::WORD_W-1:0] o_data_reg,
    output logic o_data_update,
    output logic o_settled,
    output logic o_overrun
);
    sdf_stream_if #(.WIDTH(sdf_pkg::WORD_W)) wr_if ();
    sdf_stream_if #(.WIDTH(sdf_pkg::WORD_W)) rd_if ();

    logic [1:0] sel;
    logic [sdf_pkg::MOD_CNT_W-1:0] mod_cnt_reg, mod_cnt_next;
    sdf_pkg::sdf_acc_t integ_reg [sdf_pkg::STAGES];
    sdf_pkg::sdf_acc_t integ_next [sdf_pkg::STAGES];
    sdf_pkg::sdf_acc_t dly_reg [sdf_pkg::STAGES];
    sdf_pkg::sdf_acc_t dly_next [sdf_pkg::STAGES];
    sdf_pkg::sdf_acc_t comb_val [sdf_pkg::STAGES+1];
    sdf_pkg::sdf_acc_t cic_reg, cic_next;
    logic cic_go_reg, cic_go_next;
    logic [sdf_pkg::DEC_W-1:0] dec_cnt_reg, dec_cnt_next;
    logic [1:0] skip_reg, skip_next;
    logic [1:0] sel_reg, sel_next;
    logic [sdf_pkg::WORD_W-1:0] word_reg, word_next;
    logic pend_reg, pend_next;
    logic update_reg, update_next;
    logic overrun_reg, overrun_next;
    logic restart, mod_tick, dec_last;
    logic [sdf_pkg::PROD_W-1:0] prod;
    logic [sdf_pkg::DUTY_W-1:0] duty;
    sdf_pkg::sdf_acc_t integ_sum [sdf_pkg::STAGES];
    logic settled_reg, settled_next;
    logic out_valid_reg, out_valid_next;
    logic [sdf_pkg::WORD_W-1:0] out_data_reg, out_data_next;

    // last count of the decimation counter
    function automatic logic [sdf_pkg::DEC_W-1:0] sdf_sat_n(input logic [1:0] s);
        sdf_sat_n = sdf_pkg::sdf_dec_n(s) - 1'b1;
    endfunction : sdf_sat_n

    assign sel = {i_filter_select_hi, i_filter_select_lo};
    assign mod_tick = (mod_cnt_reg == sdf_pkg::MOD_CNT_LAST);
    // select change restarts, since stale stages mix two N values
    assign restart = i_filter_sync || (sel != sel_reg);
    assign dec_last = (dec_cnt_reg == sdf_sat_n(sel_reg));
    // divide out N cubed by reciprocal multiply
    // rounded: a truncating cut leaves midscale one code low
    assign prod = sdf_pkg::PROD_W'(cic_reg) * sdf_pkg::PROD_W'(sdf_pkg::sdf_recip(sel_reg))
        + sdf_pkg::PROD_HALF;
    assign duty = prod[sdf_pkg::SCALE_SHIFT +: sdf_pkg::DUTY_W];

    always_comb begin
        mod_cnt_next = mod_tick ? '0 : mod_cnt_reg + 1'b1;
        integ_next = integ_reg;
        dly_next = dly_reg;
        cic_next = cic_reg;
        cic_go_next = 1'b0;
        dec_cnt_next = dec_cnt_reg;
        skip_next = skip_reg;
        sel_next = sel;
        word_next = word_reg;
        pend_next = pend_reg;
        update_next = 1'b0;
        overrun_next = overrun_reg;
        // unpipelined chain: no lag, so the third word after sync is exact
        integ_sum[0] = integ_reg[0] + sdf_pkg::sdf_acc_t'(i_mod_bit);
        for (int s = 1; s < sdf_pkg::STAGES; s++) begin
            integ_sum[s] = integ_reg[s] + integ_sum[s-1];
        end
        comb_val[0] = integ_sum[sdf_pkg::STAGES-1];
        for (int s = 0; s < sdf_pkg::STAGES; s++) begin
            comb_val[s+1] = comb_val[s] - dly_reg[s];
        end
        if (pend_reg && wr_if.ready) begin
            pend_next = 1'b0;
        end
        if (restart) begin
            mod_cnt_next = '0;
            dec_cnt_next = sdf_pkg::DEC_ZERO;
            skip_next = sdf_pkg::SETTLE_SKIP;
            for (int s = 0; s < sdf_pkg::STAGES; s++) begin
                integ_next[s] = sdf_pkg::ACC_ZERO;
                dly_next[s] = sdf_pkg::ACC_ZERO;
            end
        end else if (mod_tick) begin
            integ_next = integ_sum;
            dec_cnt_next = dec_last ? sdf_pkg::DEC_ZERO : dec_cnt_reg + 1'b1;
            if (dec_last) begin
                // comb chain at the decimated rate
                for (int s = 0; s < sdf_pkg::STAGES; s++) begin
                    dly_next[s] = comb_val[s];
                end
                cic_next = comb_val[sdf_pkg::STAGES];
                cic_go_next = 1'b1;
            end
        end
        if (cic_go_reg && !restart) begin
            if (skip_reg != 2'h0) begin
                // first two words after sync are unsettled
                skip_next = skip_reg - 1'b1;
            end else begin
                // polarity acts at the coder only
                word_next = sdf_pkg::sdf_code(duty, i_polarity_bipolar);
                update_next = 1'b1;
                // set wins: an unsent word is replaced and flagged
                overrun_next = overrun_reg || (pend_reg && !wr_if.ready);
                pend_next = 1'b1;
            end
        end
        settled_next = (skip_next == 2'h0);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mod_cnt_reg <= '0;
            for (int s = 0; s < sdf_pkg::STAGES; s++) begin
                integ_reg[s] <= sdf_pkg::ACC_ZERO;
                dly_reg[s] <= sdf_pkg::ACC_ZERO;
            end
            cic_reg <= sdf_pkg::ACC_ZERO;
            cic_go_reg <= 1'b0;
            dec_cnt_reg <= sdf_pkg::DEC_ZERO;
            skip_reg <= sdf_pkg::SETTLE_SKIP;
            sel_reg <= 2'h0;
            word_reg <= sdf_pkg::WORD_ZERO;
            pend_reg <= 1'b0;
            update_reg <= 1'b0;
            overrun_reg <= 1'b0;
            settled_reg <= 1'b0;
        end else begin
            mod_cnt_reg <= mod_cnt_next;
            integ_reg <= integ_next;
            dly_reg <= dly_next;
            cic_reg <= cic_next;
            cic_go_reg <= cic_go_next;
            dec_cnt_reg <= dec_cnt_next;
            skip_reg <= skip_next;
            sel_reg <= sel_next;
            word_reg <= word_next;
            pend_reg <= pend_next;
            update_reg <= update_next;
            overrun_reg <= overrun_next;
            settled_reg <= settled_next;
        end
    end

    // output stage: read port comes from flops, not the memory mux
    // refills when empty or popped, so back to back pops still run
    always_comb begin
        out_valid_next = out_valid_reg;
        out_data_next = out_data_reg;
        if (!out_valid_reg || i_rd_ready) begin
            out_valid_next = rd_if.valid;
            if (rd_if.valid) begin
                out_data_next = rd_if.data;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= sdf_pkg::WORD_ZERO;
        end else begin
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
        end
    end

    assign wr_if.valid = pend_reg;
    assign wr_if.data = word_reg;
    assign rd_if.ready = !out_valid_reg || i_rd_ready;
    assign o_rd_valid = out_valid_reg;
    assign o_rd_data = out_data_reg;
    assign o_data_reg = word_reg;
    assign o_data_update = update_reg;
    assign o_settled = settled_reg;
    assign o_overrun = overrun_reg;

    sdf_fifo #(
        .WIDTH(sdf_pkg::WORD_W),
        .DEPTH(sdf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .s_in(wr_if),
        .s_out(rd_if)
    );
endmodule : sdf_filter

// ===== sdf_filter_assertions.sv
`timescale 1ns/10ps
module sdf_filter_assertions (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_mod_bit,
    input wire logic i_filter_select_lo,
    input wire logic i_filter_select_hi,
    input wire logic i_polarity_bipolar,
    input wire logic i_filter_sync,
    input wire logic i_rd_ready,
    input wire logic o_rd_valid,
    input wire logic [15:0] o_rd_data,
    input wire logic [15:0] o_data_reg,
    input wire logic o_data_update,
    input wire logic o_settled,
    input wire logic o_overrun
);
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    logic seen_reg;
    logic seen_next;
    int gap_reg;
    int gap_next;
    logic [1:0] sel;
    logic restart;
    int per;
    assign sel = {i_filter_select_hi, i_filter_select_lo};
    assign restart = i_filter_sync || (sel != sel_reg);
    always_comb begin
        case (sel)
            2'h0: per = 384 * 128;
            2'h1: per = 320 * 128;
            2'h2: per = 77 * 128;
            default: per = 38 * 128;
        endcase
        sel_next = sel;
        gap_next = (restart || o_data_update) ? 1 : gap_reg + 1;
        seen_next = restart ? 1'b0 : (seen_reg || o_data_update);
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_reg <= 2'h0;
            seen_reg <= 1'b0;
            gap_reg <= 0;
        end else begin
            sel_reg <= sel_next;
            seen_reg <= seen_next;
            gap_reg <= gap_next;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_sync_held;
        i_filter_sync ##1 i_filter_sync;
    endsequence
    sequence s_head_waiting;
        o_rd_valid && !i_rd_ready;
    endsequence
    AST_RESET_QUIET: assert property (disable iff (1'b0) !i_rst_n |-> !o_rd_valid &&
        !o_data_update && !o_settled && !o_overrun && o_data_reg == 16'h0000)
        else $error("outputs not cleared in reset");
    AST_UPDATE_PULSE: assert property (o_data_update |=> !o_data_update)
        else $error("update pulse longer than one cycle");
    AST_UPDATE_SPACING: assert property (seen_reg && !restart && o_data_update |->
        gap_reg == per) else $error("word spacing differs from decimation period");
    AST_SYNC_SETTLE: assert property (!seen_reg && !restart && o_data_update |->
        gap_reg >= 3 * per && gap_reg <= 3 * per + 8) else $error("first word badly timed");
    AST_SYNC_CLEARS: assert property (s_sync_held |-> !o_settled && !o_data_update)
        else $error("word or settled flag during sync");
    AST_SETTLED_WORD: assert property (o_data_update |-> o_settled)
        else $error("word delivered while settling");
    AST_REG_HOLDS: assert property (!o_data_update |-> $stable(o_data_reg))
        else $error("data register changed without update");
    AST_FIFO_TAKES: assert property (o_data_update && !o_rd_valid |-> ##[1:2] o_rd_valid)
        else $error("word not offered to reader");
    AST_HEAD_HOLDS: assert property (s_head_waiting |=> o_rd_valid && $stable(o_rd_data))
        else $error("head word lost before pop");
    AST_OVERRUN_STICKY: assert property (o_overrun |=> o_overrun)
        else $error("overrun flag dropped");
endmodule : sdf_filter_assertions
bind sdf_filter sdf_filter_assertions u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_mod_bit(i_mod_bit), .i_filter_select_lo(i_filter_select_lo),
    .i_filter_select_hi(i_filter_select_hi), .i_polarity_bipolar(i_polarity_bipolar),
    .i_filter_sync(i_filter_sync), .i_rd_ready(i_rd_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_data_reg(o_data_reg), .o_data_update(o_data_update),
    .o_settled(o_settled), .o_overrun(o_overrun));

// ===== sdf_mod_model.sv
`timescale 1ns/10ps
module sdf_mod_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_mode,
    output logic o_mod_bit
);
    logic [6:0] div_reg;
    logic alt_reg;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg <= 7'h00;
            alt_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 7'h01;
            if (div_reg == 7'h7f) begin
                alt_reg <= !alt_reg;
            end
        end
    end
    // mode 0 zeros, 1 ones, 2 half duty
    assign o_mod_bit = (i_mode == 2'h2) ? alt_reg : i_mode[0];
endmodule : sdf_mod_model

// ===== sdf_filter_tb.sv
`timescale 1ns/10ps
module sdf_filter_tb;
    localparam int P = 38 * 128;
    logic i_ref_clk = 1'b0;
    logic i_rst_n, sel_lo, sel_hi, bip, sync, rd_ready, mod_bit;
    logic o_rd_valid, o_data_update, o_settled, o_overrun;
    logic [1:0] mode;
    logic [15:0] o_rd_data, o_data_reg;
    int bad_count = 0;
    int total_checks = 0;
    int gap;
    always #12.5 i_ref_clk = ~i_ref_clk;
    sdf_mod_model i_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mode(mode),
        .o_mod_bit(mod_bit));
    sdf_filter i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mod_bit(mod_bit),
        .i_filter_select_lo(sel_lo), .i_filter_select_hi(sel_hi), .i_polarity_bipolar(bip),
        .i_filter_sync(sync), .i_rd_ready(rd_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_data_reg(o_data_reg), .o_data_update(o_data_update),
        .o_settled(o_settled), .o_overrun(o_overrun));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic wait_update();
        gap = 0;
        do begin
            @(negedge i_ref_clk);
            gap++;
        end while (o_data_update !== 1'b1 && gap < 60000);
        check("update", 16'(o_data_update), 16'h0001);
    endtask : wait_update
    task automatic restart(input logic [1:0] sel);
        @(negedge i_ref_clk);
        {sel_hi, sel_lo} = sel;
        sync = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        sync = 1'b0;
    endtask : restart
    task automatic sc_reset();
        check("rst_valid", 16'(o_rd_valid), 16'h0000);
        check("rst_data", o_data_reg, 16'h0000);
        i_rst_n = 1'b1;
    endtask : sc_reset
    task automatic sc_midscale();
        mode = 2'h2;
        rd_ready = 1'b1;
        // each select code restarts the filter
        for (int s = 0; s < 4; s++) restart(2'(s));
        wait_update();
        check("settle", 16'(gap >= 3 * P && gap <= 3 * P + 8), 16'h0001);
        check("settled", 16'(o_settled), 16'h0001);
        check("bip_mid", o_data_reg, 16'h8000);
        bip = 1'b0;
        wait_update();
        check("gap", 16'(gap), 16'(P));
        check("uni_mid", o_data_reg, 16'h0000);
    endtask : sc_midscale
    task automatic sc_step();
        mode = 2'h1;
        // unsynced step settles by the fourth word
        repeat (4) wait_update();
        check("gap", 16'(gap), 16'(P));
        check("uni_full", o_data_reg, 16'hffff);
    endtask : sc_step
    task automatic sc_fifo();
        bip = 1'b1;
        rd_ready = 1'b0;
        for (int i = 0; i < 10; i++) begin
            wait_update();
            check("bip_full", o_data_reg, 16'hffff);
        end
        check("overrun", 16'(o_overrun), 16'h0001);
        rd_ready = 1'b1;
        // output stage, eight stored and the pending word
        for (int i = 0; i < 10; i++) begin
            check("rd_valid", 16'(o_rd_valid), 16'h0001);
            check("rd_data", o_rd_data, 16'hffff);
            @(negedge i_ref_clk);
        end
        check("empty", 16'(o_rd_valid), 16'h0000);
    endtask : sc_fifo
    initial begin
        i_rst_n = 1'b1;
        sel_lo = 1'b1;
        sel_hi = 1'b1;
        bip = 1'b1;
        sync = 1'b0;
        rd_ready = 1'b0;
        mode = 2'h0;
        // a clean falling edge, so reset acts before the first clock edge
        #1;
        i_rst_n = 1'b0;
        repeat (6) @(negedge i_ref_clk);
        sc_reset();
        sc_midscale();
        sc_step();
        sc_fifo();
        test_done();
    end
    initial begin
        repeat (95000) @(posedge i_ref_clk);
        bad_count++;
        $display("ERROR watchdog expected done seen timeout");
        test_done();
    end
endmodule : sdf_filter_tb
